// >>> rtl/vsup_supervisor.sv
// Voltage supervisor top: register slave, masking, thresholds and debounce channels.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module vsup_supervisor #(
    parameter int NUM_REG = 4,
    parameter int TICK_DIV = vsup_pkg::TICK_DIV
) (
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write address channel.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // One-time-programmed level codes, two bits per regulator.
    input wire logic [2*NUM_REG-1:0] undervolt_level_code,
    input wire logic [2*NUM_REG-1:0] overvolt_level_code,
    // Regulator status and analog comparator results.
    input wire logic [NUM_REG-1:0] regOn,
    input wire logic [NUM_REG-1:0] regInRegulation,
    input wire vsup_pkg::vsup_pair_t cmpTrip,
    // Trip levels to the comparators, percent of nominal.
    output logic [7*NUM_REG-1:0] uvTripPct,
    output logic [7*NUM_REG-1:0] ovTripPct,
    // Debounced indicators and interrupt.
    output vsup_pkg::vsup_pair_t monState,
    output logic irq
);

    // ****************************************************************
    // Slow tick divider
    // ****************************************************************
    localparam int DIV_W = $clog2(TICK_DIV);
    logic [DIV_W-1:0] divCnt_reg;
    logic tick_reg;
    wire logic divWrap = (divCnt_reg == DIV_W'(TICK_DIV - 1));

    // One mclk pulse every slow period keeps a single clock domain.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            divCnt_reg <= divWrap ? '0 : divCnt_reg + 1'b1;
            tick_reg <= divWrap;
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0] uvDebSel_reg;
    logic [1:0] ovDebSel_reg;
    logic secureEn_reg;
    logic unlocked_reg;
    logic [NUM_REG-1:0] monitor_enable_reg;
    logic [2*NUM_REG-1:0] irqStat_reg;
    logic [2*NUM_REG-1:0] irqEn_reg;

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;

    // Address and data may arrive in either order; each is held until both are in.
    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake = s_axi_wvalid && s_axi_wready;
    wire logic haveAw = awHeld_reg || awTake;
    wire logic haveW = wHeld_reg || wTake;
    wire logic [7:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    wire logic [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
    wire logic [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    wire logic wrFire = haveAw && haveW && !s_axi_bvalid;
    wire logic wrLow = wrFire && wrStrb[0];

    // Write decode.
    wire logic hitCtrl = (wrAddr == vsup_pkg::OFS_CTRL);
    wire logic hitMonEn = (wrAddr == vsup_pkg::OFS_MONEN);
    wire logic hitUnlock = (wrAddr == vsup_pkg::OFS_UNLOCK);
    wire logic hitIrqClr = (wrAddr == vsup_pkg::OFS_IRQ_CLR);
    wire logic hitIrqEn = (wrAddr == vsup_pkg::OFS_IRQ_EN);
    wire logic wrKnown = hitCtrl || hitMonEn || hitUnlock || hitIrqClr || hitIrqEn;

    // A monitor enable change needs the unlock key first while secure access is on.
    wire logic monEnAllowed = !secureEn_reg || unlocked_reg;
    wire logic monEnWrite = wrLow && hitMonEn && monEnAllowed;
    wire logic keyMatch = wrFire && hitUnlock && (wrData == vsup_pkg::UNLOCK_KEY);

    // Handshake bookkeeping and the write response.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= vsup_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            awHeld_reg <= wrFire ? 1'b0 : haveAw;
            wHeld_reg <= wrFire ? 1'b0 : haveW;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrKnown ? vsup_pkg::RESP_OKAY : vsup_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control and enable registers
    // ****************************************************************
    // The unlock is single-use: any following write other than the key disarms it, so a stray
    // write cannot leave the enables open indefinitely.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            uvDebSel_reg <= vsup_pkg::UNDERVOLT_DEBOUNCE_SEL_RESET;
            ovDebSel_reg <= vsup_pkg::OVERVOLT_DEBOUNCE_SEL_RESET;
            secureEn_reg <= vsup_pkg::SECURE_RESET;
            unlocked_reg <= 1'b0;
            monitor_enable_reg <= vsup_pkg::MONEN_RESET;
            irqEn_reg <= '0;
        end else begin
            if (wrLow && hitCtrl) begin
                uvDebSel_reg <= wrData[vsup_pkg::CTRL_UVDB_LSB +: 2];
                ovDebSel_reg <= wrData[vsup_pkg::CTRL_OVDB_LSB +: 2];
                secureEn_reg <= wrData[vsup_pkg::CTRL_SECURE_BIT];
            end
            if (monEnWrite) begin
                monitor_enable_reg <= wrData[NUM_REG-1:0];
            end
            if (wrFire) begin
                unlocked_reg <= keyMatch;
            end
            if (wrLow && hitIrqEn) begin
                irqEn_reg <= wrData[2*NUM_REG-1:0];
            end
        end
    end

    // ****************************************************************
    // Regulation masking
    // ****************************************************************
    logic [NUM_REG-1:0] armed_reg;
    wire logic [NUM_REG-1:0] chActive = monitor_enable_reg & armed_reg;

    // Arming waits for regulation after switch-on and drops when the regulator is off.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_reg <= '0;
        end else begin
            armed_reg <= regOn & (armed_reg | regInRegulation);
        end
    end

    // ****************************************************************
    // Debounce limits
    // ****************************************************************
    // One undervoltage setting serves all channels; the overvoltage one is shared.
    wire logic [vsup_pkg::DB_W-1:0] uvLimit =
        vsup_pkg::db_ticks(vsup_pkg::UNDERVOLT_DEBOUNCE_SEL_US[uvDebSel_reg]);
    wire logic [vsup_pkg::DB_W-1:0] ovLimit =
        vsup_pkg::db_ticks(vsup_pkg::OVERVOLT_DEBOUNCE_SEL_US[ovDebSel_reg]);

    // ****************************************************************
    // Per-regulator channels
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < NUM_REG; ch++) begin : g_ch
            // Each regulator owns an independent pair of debounce channels.
            vsup_debounce #(
                .DB_W(vsup_pkg::DB_W)
            ) u_uv (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .tick(tick_reg),
                .active(chActive[ch]),
                .cond(cmpTrip.uv[ch]),
                .limit(uvLimit),
                .state(monState.uv[ch])
            );

            vsup_debounce #(
                .DB_W(vsup_pkg::DB_W)
            ) u_ov (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .tick(tick_reg),
                .active(chActive[ch]),
                .cond(cmpTrip.ov[ch]),
                .limit(ovLimit),
                .state(monState.ov[ch])
            );

            // Trip levels step two percent per code away from nominal.
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    uvTripPct[7*ch +: 7] <= vsup_pkg::UV_BASE_PCT;
                    ovTripPct[7*ch +: 7] <= vsup_pkg::OV_BASE_PCT;
                end else begin
                    uvTripPct[7*ch +: 7] <= vsup_pkg::UV_BASE_PCT
                        - 7'(vsup_pkg::PCT_STEP * undervolt_level_code[2*ch +: 2]);
                    ovTripPct[7*ch +: 7] <= vsup_pkg::OV_BASE_PCT
                        + 7'(vsup_pkg::PCT_STEP * overvolt_level_code[2*ch +: 2]);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [2*NUM_REG-1:0] prevState_reg;
    wire logic [2*NUM_REG-1:0] curState = monState;
    wire logic [2*NUM_REG-1:0] riseEvt = curState & ~prevState_reg;
    wire logic [2*NUM_REG-1:0] clrMask =
        (wrLow && hitIrqClr) ? wrData[2*NUM_REG-1:0] : '0;

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prevState_reg <= '0;
            irqStat_reg <= '0;
        end else begin
            prevState_reg <= curState;
            irqStat_reg <= (irqStat_reg & ~clrMask) | riseEvt;
        end
    end

    assign irq = |(irqStat_reg & irqEn_reg);

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    wire logic arTake = s_axi_arvalid && s_axi_arready;

    // Read multiplexer; reserved bits and write-only registers read as zero.
    logic [31:0] rdMux;
    logic rdKnown;
    always_comb begin
        rdMux = '0;
        rdKnown = 1'b1;
        unique case (s_axi_araddr)
            vsup_pkg::OFS_CTRL: begin
                rdMux[vsup_pkg::CTRL_UVDB_LSB +: 2] = uvDebSel_reg;
                rdMux[vsup_pkg::CTRL_OVDB_LSB +: 2] = ovDebSel_reg;
                rdMux[vsup_pkg::CTRL_SECURE_BIT] = secureEn_reg;
            end
            vsup_pkg::OFS_MONEN: rdMux[NUM_REG-1:0] = monitor_enable_reg;
            vsup_pkg::OFS_UNLOCK: rdMux[0] = unlocked_reg;
            vsup_pkg::OFS_STATUS: begin
                rdMux[2*NUM_REG-1:0] = curState;
                rdMux[2*NUM_REG +: NUM_REG] = armed_reg;
            end
            vsup_pkg::OFS_LEVELS: begin
                rdMux[2*NUM_REG-1:0] = undervolt_level_code;
                rdMux[2*NUM_REG +: 2*NUM_REG] = overvolt_level_code;
            end
            vsup_pkg::OFS_IRQ_STAT: rdMux[2*NUM_REG-1:0] = irqStat_reg;
            vsup_pkg::OFS_IRQ_CLR: rdMux = '0;
            vsup_pkg::OFS_IRQ_EN: rdMux[2*NUM_REG-1:0] = irqEn_reg;
            default: rdKnown = 1'b0;
        endcase
    end

    // Read data are registered and held until the master takes them.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= vsup_pkg::RESP_OKAY;
        end else if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdKnown ? vsup_pkg::RESP_OKAY : vsup_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : vsup_supervisor
`default_nettype wire

// >>> rtl/vsup_pkg.sv
// Package of constants, register map and carrier types for the voltage supervisor.
package vsup_pkg;

    // ****************************************************************
    // Clocking and timing
    // ****************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int SLOW_HZ = 100_000;
    localparam int TICK_NS = 1_000_000_000 / SLOW_HZ;
    localparam int TICK_DIV = CLK_HZ / SLOW_HZ;
    localparam int NUM_REG = 4;
    localparam int DB_W = 4;
    localparam int UNDERVOLT_DEBOUNCE_SEL_US[4] = '{5, 15, 30, 40};
    localparam int OVERVOLT_DEBOUNCE_SEL_US[4] = '{30, 50, 80, 125};

    // A least time rounds up to whole ticks, never below one tick.
    function automatic logic [DB_W-1:0] db_ticks(input int us);
        int t;
        t = (us * 1000 + TICK_NS - 1) / TICK_NS;
        if (t < 1) begin
            t = 1;
        end
        return DB_W'(t);
    endfunction : db_ticks

    // ****************************************************************
    // Trip levels in percent of nominal
    // ****************************************************************
    localparam logic [6:0] UV_BASE_PCT = 7'h5F;
    localparam logic [6:0] OV_BASE_PCT = 7'h69;
    localparam logic [6:0] PCT_STEP = 7'h02;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MONEN = 8'h04;
    localparam logic [7:0] OFS_UNLOCK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_LEVELS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

    // Control field positions and reset values.
    localparam int CTRL_UVDB_LSB = 0;
    localparam int CTRL_OVDB_LSB = 2;
    localparam int CTRL_SECURE_BIT = 4;
    localparam logic [1:0] UNDERVOLT_DEBOUNCE_SEL_RESET = 2'h2;
    localparam logic [1:0] OVERVOLT_DEBOUNCE_SEL_RESET = 2'h0;
    localparam logic SECURE_RESET = 1'b0;
    localparam logic [3:0] MONEN_RESET = 4'hF;
    localparam logic [31:0] UNLOCK_KEY = 32'h5EC0_0A5A;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [NUM_REG-1:0] ov;
        logic [NUM_REG-1:0] uv;
    } vsup_pair_t;

endpackage : vsup_pkg

// >>> rtl/vsup_debounce.sv
// One debounce channel: a tick counter that qualifies a comparator level.
`timescale 1ns/100ps
`default_nettype none
module vsup_debounce #(
    parameter int DB_W = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic active,
    input wire logic cond,
    input wire logic [DB_W-1:0] limit,
    output logic state
);
    logic [DB_W-1:0] cnt_reg;
    logic [DB_W-1:0] cnt_next;
    logic state_next;
    wire logic reached = (cnt_reg >= limit);

    // Counts ticks while the condition holds; a drop or inactive channel restarts.
    always_comb begin
        cnt_next = cnt_reg;
        state_next = state;
        if (!active || !cond) begin
            cnt_next = '0;
            state_next = 1'b0;
        end else if (reached) begin
            state_next = 1'b1;
        end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Counter and indicator flops.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            state <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            state <= state_next;
        end
    end
endmodule : vsup_debounce
`default_nettype wire

// >>> dv/vsup_checker.sv
// Port-level assertions for the voltage supervisor.
`timescale 1ns/100ps
`default_nettype none
module vsup_checker #(
    parameter int TICK_DIV = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] undervolt_level_code,
    input wire logic [7:0] overvolt_level_code,
    input wire logic [3:0] regOn,
    input wire logic [3:0] regInRegulation,
    input wire vsup_pkg::vsup_pair_t cmpTrip,
    input wire logic [27:0] uvTripPct,
    input wire logic [27:0] ovTripPct,
    input wire vsup_pkg::vsup_pair_t monState
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    vsup_pkg::vsup_pair_t prevState;
    logic [7:0] sinceRise;
    wire logic anyRise = |(monState & ~prevState);

    // Cycles since the last indicator rise, saturating so it never wraps.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prevState <= 8'h00;
            sinceRise <= 8'hFF;
        end else begin
            prevState <= monState;
            sinceRise <= anyRise ? 8'h00 : sinceRise + 8'((sinceRise != 8'hFF));
        end
    end

    // Expected trip levels, two percent per code step from the base.
    function automatic logic [27:0] pctExp(input logic [7:0] c, input logic [6:0] b,
                                           input logic up);
        logic [27:0] r;
        for (int i = 0; i < 4; i++) begin
            r[7*i +: 7] = up ? b + {4'h0, c[2*i +: 2], 1'b0} : b - {4'h0, c[2*i +: 2], 1'b0};
        end
        return r;
    endfunction : pctExp

    default clocking dc @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_uv_level: assert property (
        $stable(undervolt_level_code) |=>
        uvTripPct == pctExp($past(undervolt_level_code), 7'h5F, 1'b0))
        else $error("Undervoltage trip level does not follow its code.");
    a_ov_level: assert property (
        $stable(overvolt_level_code) |=>
        ovTripPct == pctExp($past(overvolt_level_code), 7'h69, 1'b1))
        else $error("Overvoltage trip level does not follow its code.");
    a_off_quiet: assert property (
        ((monState.uv | monState.ov) & ~$past(regOn, 2)) == 4'h0)
        else $error("Indicator set on a regulator that is off.");
    a_mask_until_reg: assert property (
        ((monState.uv | monState.ov) & ~$past(regOn, 3) & ~$past(regInRegulation, 2)) == 4'h0)
        else $error("Indicator set before regulation was reached.");
    a_drop_clears: assert property (
        (monState & ~$past(cmpTrip)) == 8'h00)
        else $error("Indicator stands without its condition.");
    a_ov_persist: assert property (
        |(monState.ov & ~prevState.ov) |->
        ((monState.ov & ~prevState.ov)
            & ~($past(cmpTrip.ov) & $past(cmpTrip.ov, 2*TICK_DIV-1))) == 4'h0)
        else $error("Overvoltage indicator set before its shortest interval.");
    a_tick_space: assert property (
        anyRise |-> sinceRise >= ((TICK_DIV > 256) ? 8'hFF : 8'(TICK_DIV - 1)))
        else $error("Indicator rise off the slow tick grid.");
    a_b_single: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response held after it was taken.");
endmodule : vsup_checker
`default_nettype wire

// >>> dv/vsup_cmp_model.sv
// Comparator model: feedback level against the trip levels of each channel.
`timescale 1ns/100ps
`default_nettype none
module vsup_cmp_model (
    input wire logic [27:0] fbPct,
    input wire logic [27:0] uvTripPct,
    input wire logic [27:0] ovTripPct,
    output vsup_pkg::vsup_pair_t cmpTrip
);
    // Ideal comparators; hysteresis is left out, so a level exactly at trip does not fire.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmpTrip.uv[i] = fbPct[7*i +: 7] < uvTripPct[7*i +: 7];
            cmpTrip.ov[i] = fbPct[7*i +: 7] > ovTripPct[7*i +: 7];
        end
    end
endmodule : vsup_cmp_model
`default_nettype wire

// >>> dv/test_vsup_supervisor.sv
// Self-checking bench for the voltage supervisor.
`timescale 1ns/100ps
`default_nettype none
module test_vsup_supervisor;
    localparam int TD = 8;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic awValid, wValid, bReady, arValid, rReady, awReady, wReady, bValid, arReady, rValid;
    logic irq;
    logic [7:0] awAddr, arAddr, uvCode, ovCode;
    logic [31:0] wData, rData, rd;
    logic [3:0] wStrb, regOn, inReg;
    logic [1:0] bResp, rResp, rsp;
    logic [27:0] fbPct, uvPct, ovPct;
    vsup_pkg::vsup_pair_t cmpTrip, monState;
    int uvUs[4] = '{5, 15, 30, 40};
    int ovUs[4] = '{30, 50, 80, 125};
    int error_cnt = 0;
    int n_tests = 0;

    vsup_supervisor #(.NUM_REG(4), .TICK_DIV(TD)) dut (
        .mclk(mclk), .sys_rst(sysRst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .undervolt_level_code(uvCode), .overvolt_level_code(ovCode), .regOn(regOn),
        .regInRegulation(inReg), .cmpTrip(cmpTrip), .uvTripPct(uvPct), .ovTripPct(ovPct),
        .monState(monState), .irq(irq));
    vsup_cmp_model cmp (.fbPct(fbPct), .uvTripPct(uvPct), .ovTripPct(ovPct), .cmpTrip(cmpTrip));

    // Free-running 50 MHz clock.
    always #10 mclk = ~mclk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // One AXI write; each channel is released at the edge where it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (bValid !== 1'b1 && n < 40);
        bReady <= 1'b0;
        rsp = bResp;
        if (bValid !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wr

    // One AXI read, then a compare of response and, when OKAY, of the data.
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arReady) arValid <= 1'b0;
        end while (rValid !== 1'b1 && n < 40);
        rReady <= 1'b0;
        rd = rData;
        chk({30'h0, rResp}, {30'h0, er});
        if (er === 2'h0) chk(rd, exp);
        if (rValid !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : rdChk

    // Holds a trip on channel 0, times the indicator, then lets the level recover.
    task automatic timeTrip(input logic ov, input int lim);
        int n;
        n = 0;
        @(posedge mclk);
        fbPct[6:0] <= ov ? 7'h78 : 7'h50;
        do begin
            @(posedge mclk);
            n++;
        end while ((ov ? monState.ov[0] : monState.uv[0]) !== 1'b1 && n < 300);
        chk({31'h0, n >= (lim - 1) * TD && n <= lim * TD + 2}, 32'h1);
        fbPct[6:0] <= 7'h64;
        repeat (2) @(posedge mclk);
        chk({24'h0, monState}, 32'h0);
    endtask : timeTrip

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady} = '0;
        wStrb = 4'hF;
        regOn = 4'hF;
        inReg = 4'hF;
        fbPct = {4{7'h64}};
        uvCode = 8'h00;
        ovCode = 8'h00;
        repeat (10) @(posedge mclk);
        sysRst <= 1'b0;
        rdChk(8'h00, 32'h2, 2'h0);
        rdChk(8'h04, 32'hF, 2'h0);
        rdChk(8'h20, 32'h0, 2'h2);
        wr(8'h24, 32'h0);
        chk({30'h0, rsp}, 32'h2);
        $display("Test reset values done");
        for (int c = 0; c < 4; c++) begin
            uvCode <= {4{c[1:0]}};
            ovCode <= {4{c[1:0]}};
            repeat (3) @(posedge mclk);
            chk({4'h0, uvPct}, {4'h0, {4{7'h5F - 7'(2 * c)}}});
            chk({4'h0, ovPct}, {4'h0, {4{7'h69 + 7'(2 * c)}}});
            rdChk(8'h10, {16'h0, {8{c[1:0]}}}, 2'h0);
        end
        uvCode <= 8'h00;
        ovCode <= 8'h00;
        $display("Test trip levels done");
        wr(8'h1C, 32'h1);
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'(s));
            timeTrip(1'b0, (uvUs[s] + 9) / 10);
        end
        fbPct[6:0] <= 7'h50;
        repeat (20) @(posedge mclk);
        fbPct[6:0] <= 7'h64;
        timeTrip(1'b0, 4);
        chk({31'h0, irq}, 32'h1);
        rdChk(8'h14, 32'h1, 2'h0);
        wr(8'h18, 32'h1);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'((s << 2) | 2));
            timeTrip(1'b1, (ovUs[s] + 9) / 10);
        end
        chk({31'h0, irq}, 32'h0);
        rdChk(8'h14, 32'h10, 2'h0);
        $display("Test debounce and interrupt done");
        fbPct[13:7] <= 7'h50;
        repeat (40) @(posedge mclk);
        chk({31'h0, monState.uv[1]}, 32'h1);
        rdChk(8'h0C, 32'hF02, 2'h0);
        wr(8'h04, 32'hD);
        @(posedge mclk);
        chk({24'h0, monState}, 32'h0);
        repeat (40) @(posedge mclk);
        chk({31'h0, monState.uv[1]}, 32'h0);
        wr(8'h00, 32'h1A);
        wr(8'h04, 32'hF);
        rdChk(8'h04, 32'hD, 2'h0);
        wr(8'h08, vsup_pkg::UNLOCK_KEY);
        wr(8'h04, 32'hF);
        rdChk(8'h04, 32'hF, 2'h0);
        repeat (40) @(posedge mclk);
        chk({31'h0, monState.uv[1]}, 32'h1);
        fbPct[13:7] <= 7'h64;
        $display("Test monitor enable done");
        regOn[2] <= 1'b0;
        inReg[2] <= 1'b0;
        fbPct[20:14] <= 7'h50;
        repeat (5) @(posedge mclk);
        regOn[2] <= 1'b1;
        repeat (60) @(posedge mclk);
        chk({31'h0, monState.uv[2]}, 32'h0);
        inReg[2] <= 1'b1;
        repeat (40) @(posedge mclk);
        chk({31'h0, monState.uv[2]}, 32'h1);
        $display("Test masking done");
        report_and_stop();
    end

    // Cuts a hang short.
    initial begin
        repeat (50000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
endmodule : test_vsup_supervisor

bind vsup_supervisor vsup_checker #(.TICK_DIV(TICK_DIV)) chkr (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .undervolt_level_code(undervolt_level_code), .overvolt_level_code(overvolt_level_code),
    .regOn(regOn), .regInRegulation(regInRegulation), .cmpTrip(cmpTrip),
    .uvTripPct(uvTripPct), .ovTripPct(ovTripPct), .monState(monState));
`default_nettype wire
